// ===== odt_cfg.svh
// Purpose: Constants for the on/off delay timer pair.
// Assumes: 50 MHz clock, one shared delay source for both timers.
// Notes: Times are in nanoseconds, counts are derived from them.
//
// Notes on behaviour
// R1: On-delay output rises after trigger held high.
// R2: On-delay output drops at once when trigger low.
// R3: Off-delay output falls after trigger held low.
// R4: Off-delay output rises at once when trigger high.
// R5: Delay setpoint is unsigned 0 to 65535.
// R6: Stored setpoint used when no input connected.
// R7: Connected delay input overrides stored setpoint.
// R8: Delay input accepts word, analog or long.
// R9: Count ticks; restart count when trigger drops.
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

// Clock period of the controller cycle clock.
`define ODT_CLK_PERIOD_NS  20
// Period of one delay tick.
`define ODT_TICK_PERIOD_NS 1000000
// Clock cycles per delay tick, derived from the two periods.
`define ODT_TICK_CYCLES    (`ODT_TICK_PERIOD_NS / `ODT_CLK_PERIOD_NS)
// Width of the tick prescaler.
`define ODT_TICK_W         16
// Width of the delay count and the setpoint.
`define ODT_DELAY_W        16
// Largest delay that the setpoint can express.
`define ODT_DELAY_MAX      16'hFFFF
// Reset value of counts and of the held delay.
`define ODT_DELAY_RST      16'h0000
// Lowest bit of the integer part of an unsigned 16.16 analog value.
`define ODT_ANA_INT_LSB    16
// Lowest bit of the upper half of a long value.
`define ODT_LONG_HI_LSB    16

`endif

// ===== odt_pkg.sv
// Purpose: Types shared by the on/off delay timer files.
// Assumes: Constants come from odt_cfg.svh.
// Notes: State of odt_top and of odt_delay_chan is one packed struct each.
`include "odt_cfg.svh"

package odt_pkg;

  // Kind of value that drives the delay input.
  typedef enum logic [1:0] {
    ODT_SRC_WORD   = 2'b00,
    ODT_SRC_ANALOG = 2'b01,
    ODT_SRC_LONG   = 2'b10
  } odt_src_t;

  // State of one delay channel.
  typedef struct packed {
    logic [`ODT_DELAY_W-1:0] cnt;  // Elapsed ticks at the active level.
    logic                    out;  // Registered timer output.
  } odt_chan_st_t;

  // State of the top level: prescaler and held delay.
  typedef struct packed {
    logic [`ODT_TICK_W-1:0]  tick_cnt;  // Clock cycles within one tick.
    logic                    tick;      // One-cycle tick pulse.
    logic [`ODT_DELAY_W-1:0] delay;     // Delay in ticks for both channels.
  } odt_top_st_t;

endpackage

// ===== odt_delay_chan.sv
// Purpose: One delay channel, on-delay or off-delay by parameter.
// Assumes: Trigger and tick are synchronous to clk_i.
// Notes: ASSERT_LVL 1 gives on-delay, 0 gives off-delay.
`timescale 1ns/10ps
`default_nettype none
`include "odt_cfg.svh"

module odt_delay_chan #(
  parameter bit ASSERT_LVL = 1'b1
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    trg_i,
  input  wire logic                    tick_i,
  input  wire logic [`ODT_DELAY_W-1:0] delay_i,
  output logic                         out_o
);

  odt_pkg::odt_chan_st_t st_q;  // Registered channel state.
  odt_pkg::odt_chan_st_t st_d;  // Next channel state.

  // Next state. The idle level passes straight through; the delayed
  // level waits until the tick count reaches the delay.
  always_comb begin
    st_d = st_q;
    if (trg_i != ASSERT_LVL) begin
      st_d.cnt = `ODT_DELAY_RST;  // R9
      st_d.out = trg_i;  // R2 R4
    end else if (st_q.cnt >= delay_i) begin
      st_d.out = ASSERT_LVL;  // R1 R3
    end else if (tick_i) begin
      // Counting stops at the delay, so the count cannot wrap.
      st_d.cnt = st_q.cnt + 16'h0001;  // R9
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_o = st_q.out;

  a_idle_pass: assert property (  // R2 R4
    @(posedge clk_i) disable iff (rst_i)
    (trg_i != ASSERT_LVL) |=> (out_o == $past(trg_i)))
    else $error("Idle trigger level did not pass to the output.");

  a_count_clear: assert property (  // R9
    @(posedge clk_i) disable iff (rst_i)
    (trg_i != ASSERT_LVL) |=> (st_q.cnt == `ODT_DELAY_RST))
    else $error("Count not restarted on idle trigger.");

  a_no_early: assert property (  // R1 R3
    @(posedge clk_i) disable iff (rst_i)
    (out_o == ASSERT_LVL && $past(out_o) != ASSERT_LVL) |->
      ($past(trg_i) == ASSERT_LVL && $past(st_q.cnt) >= $past(delay_i)))
    else $error("Output changed before the delay expired.");

  a_tick_step: assert property (  // R9
    @(posedge clk_i) disable iff (rst_i)
    (trg_i == ASSERT_LVL && st_q.cnt < delay_i && tick_i) |=>
      (st_q.cnt == $past(st_q.cnt) + 16'h0001))
    else $error("Count did not advance on a tick.");

  a_hold_count: assert property (  // R9
    @(posedge clk_i) disable iff (rst_i)
    (trg_i == ASSERT_LVL && !tick_i) |=> $stable(st_q.cnt))
    else $error("Count moved without a tick.");

endmodule
`default_nettype wire

// ===== odt_top.sv
// Purpose: Pair of delay timers, one on-delay and one off-delay.
// Assumes: All inputs are synchronous to clk_i; the source of the
//          delay input keeps the value within its documented range.
// Notes: Both timers share one delay, taken from the stored setting or
//        from the connected delay input, held in a register.
`timescale 1ns/10ps
`default_nettype none
`include "odt_cfg.svh"

module odt_top #(
  // Clock cycles per delay tick; shorten it for simulation.
  parameter int unsigned TICK_CYCLES = `ODT_TICK_CYCLES
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    on_trg_i,
  input  wire logic                    off_trg_i,
  input  wire logic [`ODT_DELAY_W-1:0] delay_cfg_i,
  input  wire logic                    delay_conn_i,
  input  wire logic [1:0]              delay_type_i,
  input  wire logic [15:0]             delay_word_i,
  input  wire logic [31:0]             delay_ana_i,
  input  wire logic [31:0]             delay_long_i,
  output logic                         on_delay_out_o,
  output logic                         off_delay_out_o
);

  // Last count of the prescaler, cut to its width once here.
  localparam logic [`ODT_TICK_W-1:0] TICK_LAST = `ODT_TICK_W'(TICK_CYCLES - 1);

  odt_pkg::odt_top_st_t st_q;  // Registered top state.
  odt_pkg::odt_top_st_t st_d;  // Next top state.

  // Converts a connected delay value of any accepted kind to a tick
  // count. Values beyond the count range saturate at the maximum
  // instead of wrapping, since a wrapped delay would fire far too soon.
  function automatic logic [`ODT_DELAY_W-1:0] odt_conv(
    input logic [1:0]  src,
    input logic [15:0] word,
    input logic [31:0] ana,
    input logic [31:0] lng
  );
    logic [`ODT_DELAY_W-1:0] res;
    res = word;
    case (odt_pkg::odt_src_t'(src))
      odt_pkg::ODT_SRC_WORD: begin
        // A word already spans the whole range.
        res = word;
      end
      odt_pkg::ODT_SRC_ANALOG: begin
        // The fraction is dropped; only whole ticks are counted.
        res = ana[`ODT_ANA_INT_LSB +: `ODT_DELAY_W];
      end
      odt_pkg::ODT_SRC_LONG: begin
        // Any bit above the low half means the value is out of range.
        if (lng[31:`ODT_LONG_HI_LSB] != 16'h0000) begin
          res = `ODT_DELAY_MAX;
        end else begin
          res = lng[`ODT_DELAY_W-1:0];
        end
      end
      default: begin
        // The unused code is read as a plain word.
        res = word;
      end
    endcase
    return res;
  endfunction

  // Next state: tick prescaler and delay selection.
  always_comb begin
    st_d = st_q;
    // The prescaler wraps once per tick and flags that cycle.
    if (st_q.tick_cnt >= TICK_LAST) begin
      st_d.tick_cnt = '0;  // R9
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
      st_d.tick     = 1'b0;
    end
    // A connected input wins over the stored setting.
    if (delay_conn_i) begin
      st_d.delay = odt_conv(delay_type_i, delay_word_i,  // R7 R8
                            delay_ana_i, delay_long_i);
    end else begin
      st_d.delay = delay_cfg_i;  // R6 R5
    end
  end

  // State register. The delay is held so that a changing source
  // reaches both channels in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.tick_cnt <= '0;
      st_q.tick     <= 1'b0;
      st_q.delay    <= `ODT_DELAY_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // On-delay channel: active level is high.
  odt_delay_chan #(
    .ASSERT_LVL (1'b1)
  ) u_on_chan (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .trg_i   (on_trg_i),
    .tick_i  (st_q.tick),
    .delay_i (st_q.delay),
    .out_o   (on_delay_out_o)
  );

  // Off-delay channel: active level is low.
  odt_delay_chan #(
    .ASSERT_LVL (1'b0)
  ) u_off_chan (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .trg_i   (off_trg_i),
    .tick_i  (st_q.tick),
    .delay_i (st_q.delay),
    .out_o   (off_delay_out_o)
  );

  // A falling on-trigger and the next sample.
  sequence s_on_drop;
    on_trg_i ##1 !on_trg_i;
  endsequence

  // A rising off-trigger and the next sample.
  sequence s_off_rise;
    !off_trg_i ##1 off_trg_i;
  endsequence

  a_on_drop: assert property (  // R2
    @(posedge clk_i) disable iff (rst_i)
    s_on_drop |=> !on_delay_out_o)
    else $error("On-delay output did not drop one cycle after trigger.");

  a_off_rise: assert property (  // R4
    @(posedge clk_i) disable iff (rst_i)
    s_off_rise |=> off_delay_out_o)
    else $error("Off-delay output did not rise one cycle after trigger.");

  // A zero delay lets the output follow one clock after the trigger, so
  // only then may the trigger have been high for a single sample.
  a_on_rise_held: assert property (  // R1
    @(posedge clk_i) disable iff (rst_i)
    $rose(on_delay_out_o) |->
      $past(on_trg_i) && ($past(on_trg_i, 2) || $past(st_q.delay) == `ODT_DELAY_RST))
    else $error("On-delay output rose without a held trigger.");

  a_tick_period: assert property (  // R9
    @(posedge clk_i) disable iff (rst_i)
    st_q.tick |-> ($past(st_q.tick_cnt) == TICK_LAST && st_q.tick_cnt == '0))
    else $error("Tick pulse not at the prescaler wrap.");

  a_stored_delay: assert property (  // R6
    @(posedge clk_i) disable iff (rst_i)
    !delay_conn_i |=> (st_q.delay == $past(delay_cfg_i)))
    else $error("Stored delay not used while unconnected.");

  a_conn_word: assert property (  // R7
    @(posedge clk_i) disable iff (rst_i)
    (delay_conn_i && delay_type_i == odt_pkg::ODT_SRC_WORD) |=>
      (st_q.delay == $past(delay_word_i)))
    else $error("Connected word delay not taken.");

  a_long_sat: assert property (  // R8
    @(posedge clk_i) disable iff (rst_i)
    (delay_conn_i && delay_type_i == odt_pkg::ODT_SRC_LONG &&
     delay_long_i[31:16] != 16'h0000) |=> (st_q.delay == `ODT_DELAY_MAX))
    else $error("Out of range long delay did not saturate.");

  a_ana_int: assert property (  // R8
    @(posedge clk_i) disable iff (rst_i)
    (delay_conn_i && delay_type_i == odt_pkg::ODT_SRC_ANALOG) |=>
      (st_q.delay == $past(delay_ana_i[31:16])))
    else $error("Analog delay not truncated to its whole part.");

  // The checks below guard the delayed edges against glitches and the
  // remaining decode paths of the delay input. They matter most when the
  // delay source changes while a timer is running.

  // On-delay output high with its trigger still high.
  sequence s_on_keep;
    on_delay_out_o && on_trg_i;
  endsequence

  // Off-delay output low with its trigger still low.
  sequence s_off_keep;
    !off_delay_out_o && !off_trg_i;
  endsequence

  // Mirror of the on-delay check: a fall needs a held low trigger unless
  // the delay is zero, in which case one sample suffices.
  a_off_fall_held: assert property (  // R3
    @(posedge clk_i) disable iff (rst_i)
    $fell(off_delay_out_o) |->
      !$past(off_trg_i) && (!$past(off_trg_i, 2) || $past(st_q.delay) == `ODT_DELAY_RST))
    else $error("Off-delay output fell without a held trigger.");

  // Raising the delay at run time must not pull an active output back.
  a_on_keep: assert property (  // R1
    @(posedge clk_i) disable iff (rst_i)
    s_on_keep |=> on_delay_out_o)
    else $error("On-delay output dropped while its trigger stayed high.");

  // The same holds for the off-delay output at its active low level.
  a_off_keep: assert property (  // R3
    @(posedge clk_i) disable iff (rst_i)
    s_off_keep |=> !off_delay_out_o)
    else $error("Off-delay output rose while its trigger stayed low.");

  // A long value inside the range reaches the timers unchanged.
  a_long_pass: assert property (  // R8
    @(posedge clk_i) disable iff (rst_i)
    (delay_conn_i && delay_type_i == odt_pkg::ODT_SRC_LONG &&
     delay_long_i[31:16] == 16'h0000) |=> (st_q.delay == $past(delay_long_i[15:0])))
    else $error("In range long delay not taken.");

  // The spare type code falls back to the word form.
  a_spare_word: assert property (  // R8
    @(posedge clk_i) disable iff (rst_i)
    (delay_conn_i && delay_type_i == 2'h3) |=>
      (st_q.delay == $past(delay_word_i)))
    else $error("Spare type code not read as a word.");

endmodule
`default_nettype wire

// ===== odt_src_model.sv
// Purpose: Stand-in for the function block that feeds the delay input.
// Assumes: The bench chooses the value; this model offers it in all three forms.
// Notes: The analog form carries a half fraction, so truncation is exercised.
`timescale 1ns/10ps
`default_nettype none

module odt_src_model (
  input  wire logic [31:0] val_i,
  output logic      [15:0] word_o,
  output logic      [31:0] ana_o,
  output logic      [31:0] long_o
);
  // The word supplier keeps its value within the 16-bit setpoint range.
  assign word_o = val_i[15:0];
  // Unsigned 16.16 with a nonzero fraction that the block must drop.
  assign ana_o  = {val_i[15:0], 16'h8000};
  // The long form is passed whole, so a large value would reach the block.
  assign long_o = val_i;
endmodule

`default_nettype wire

// ===== on_off_delay_timer_tb_top.sv
// Purpose: Self-checking bench for the on/off delay timer pair.
// Assumes: A short tick of four clocks; inputs change on the falling edge.
// Notes: Delay windows allow for the free-running prescaler phase.
`timescale 1ns/10ps
`default_nettype none

module on_off_delay_timer_tb_top;
  localparam int TICK = 4;  // Short tick keeps every delay but the saturated one brief.
  logic        clk_i        = 1'b0;  // Bench clock.
  logic        rst_i        = 1'b1;  // Reset held at start.
  logic        on_trg_i     = 1'b0;  // On-delay trigger.
  logic        off_trg_i    = 1'b0;  // Off-delay trigger.
  logic [15:0] delay_cfg_i  = 16'h0005;  // Stored setting.
  logic        delay_conn_i = 1'b0;  // Delay input connection.
  logic [1:0]  delay_type_i = 2'b00;  // Kind of delay input.
  logic [31:0] src_val      = 32'h0000_0000;  // Value of the feeding block.
  logic [15:0] delay_word_i;  // Word form.
  logic [31:0] delay_ana_i;  // Analog form.
  logic [31:0] delay_long_i;  // Long form.
  logic        on_delay_out_o;  // On-delay output.
  logic        off_delay_out_o;  // Off-delay output.
  int          n_mismatch   = 0;  // Failed comparisons.
  int          tests_run    = 0;  // Comparisons made.

  // Clock of 20 ns period.
  always #10 clk_i = ~clk_i;

  odt_top #(.TICK_CYCLES(TICK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .on_trg_i(on_trg_i), .off_trg_i(off_trg_i),
    .delay_cfg_i(delay_cfg_i), .delay_conn_i(delay_conn_i), .delay_type_i(delay_type_i),
    .delay_word_i(delay_word_i), .delay_ana_i(delay_ana_i), .delay_long_i(delay_long_i),
    .on_delay_out_o(on_delay_out_o), .off_delay_out_o(off_delay_out_o));

  odt_src_model u_src (
    .val_i(src_val), .word_o(delay_word_i), .ana_o(delay_ana_i), .long_o(delay_long_i));

  // One comparison; a failure is reported at once.
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Selects the delay source, then lets the held delay settle.
  task automatic set_src(input bit conn, input bit [1:0] typ, input bit [15:0] cfg,
                         input bit [31:0] val);
    @(negedge clk_i);
    delay_conn_i = conn;
    delay_type_i = typ;
    delay_cfg_i  = cfg;
    src_val      = val;
    repeat (3) @(negedge clk_i);
  endtask

  // Parks the trigger idle, goes active and times the delayed edge.
  task automatic run_delay(input bit off, input int d, input int park);
    int n;
    n = 0;
    if (off) off_trg_i = 1'b1; else on_trg_i = 1'b0;
    repeat (park) @(negedge clk_i);
    if (off) off_trg_i = 1'b0; else on_trg_i = 1'b1;
    do begin
      @(negedge clk_i);
      n++;
    end while (n < d * TICK + 8 &&
               (off ? off_delay_out_o !== 1'b0 : on_delay_out_o !== 1'b1));
    // The edge may come early by at most one partial tick.
    chk(n >= (d > 0 ? (d - 1) * TICK : 1) && n <= d * TICK + 3,
        "delayed edge out of window");
  endtask

  // Returns the trigger to idle; the output must follow after one edge.
  task automatic idle_back(input bit off);
    if (off) off_trg_i = 1'b1; else on_trg_i = 1'b0;
    @(negedge clk_i);
    chk(off ? off_delay_out_o === 1'b1 : on_delay_out_o === 1'b0,
        "idle level not immediate");
  endtask

  // A short active pulse must not fire, and a brief idle gap restarts the count.
  task automatic restart(input bit off);
    if (off) off_trg_i = 1'b0; else on_trg_i = 1'b1;
    repeat (18) begin
      @(negedge clk_i);
      chk(off ? off_delay_out_o === 1'b1 : on_delay_out_o === 1'b0, "fired before delay");
    end
    run_delay(off, 6, 1);
    idle_back(off);
    $display("test restart done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Stored setting of 5 ticks drives both timers.
  task automatic test_stored();
    run_delay(1'b0, 5, 3);
    idle_back(1'b0);
    run_delay(1'b1, 5, 3);
    idle_back(1'b1);
    $display("test stored delay done");
  endtask

  // Every kind of delay input; the stored 9 must be ignored.
  task automatic test_kinds();
    for (int t = 0; t < 4; t++) begin
      set_src(1'b1, t[1:0], 16'h0009, 32'h0000_0003);
      run_delay(1'b0, 3, 3);
      idle_back(1'b0);
    end
    $display("test delay input kinds done");
  endtask

  // An out of range long value must saturate. A wrapped delay would be
  // zero and fire at once; the full saturated delay is too long to wait for.
  task automatic test_sat();
    set_src(1'b1, 2'b10, 16'h0009, 32'h0001_0000);
    on_trg_i = 1'b1;
    repeat (40) begin
      @(negedge clk_i);
      chk(on_delay_out_o === 1'b0, "out of range long delay fired");
    end
    idle_back(1'b0);
    $display("test long saturation done");
  endtask

  // A zero delay lets each delayed edge through after one clock.
  task automatic test_zero();
    set_src(1'b1, 2'b00, 16'h0009, 32'h0000_0000);
    run_delay(1'b0, 0, 3);
    run_delay(1'b1, 0, 3);
    idle_back(1'b1);
    $display("test zero delay done");
  endtask

  // Main sequence of scenarios.
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk(on_delay_out_o === 1'b0 && off_delay_out_o === 1'b0,
        "outputs not low after reset");
    test_stored();
    set_src(1'b0, 2'b00, 16'h0006, 32'h0000_0000);
    restart(1'b0);
    restart(1'b1);
    test_kinds();
    test_sat();
    test_zero();
    report_and_stop();
  end

  // Watchdog well beyond the expected few hundred cycles.
  initial begin
    #200000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule

`default_nettype wire
